// ---- core/sadc_ctrl.sv ----
// Operation
// - Control bit 7 powers the converter on when set, off when clear; resets low.
// - Writing one to bit 6 with bit 7 set in the same write starts one conversion; writing zero does nothing.
// - Starting a conversion clears the done flag, bit 5.
// - Finishing a conversion sets the done flag.
// - Interrupt request is a separate status bit, gated by its mask; only software clears it.
// - Channel codes 0 to 9 route analog pin of the same number.
// - Channel code 31 selects the quarter-supply internal channel.
// - Converter timing always derives from the 24 MHz oscillator rate.
// - Each conversion yields a 12-bit result by successive approximation.
// - Result bits 11..4 in high register, bits 3..0 in low bits 7..4.
// - Conversion takes 6 or 36 sample clocks, then 14 conversion clocks.
// - Pin analog select bit routes pin to converter and drops pull-up.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none

module sadc_ctrl (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire sadc_pkg::sadc_wb_req_t wb_req,
  output sadc_pkg::sadc_wb_rsp_t      wb_rsp,
  input  wire logic                   comp_high,
  output sadc_pkg::sadc_analog_t      analog,
  output logic                        irq
);

  typedef struct packed {
    logic                                ack;
    logic [sadc_pkg::DAT_W-1:0]          rdata;
    logic                                power;
    logic                                done;
    logic [sadc_pkg::CH_W-1:0]           chan;
    logic                                long_sample;
    logic [sadc_pkg::CK_W-1:0]           clk_sel;
    logic [sadc_pkg::N_PINS-1:0]         pin_sel;
    logic [sadc_pkg::RES_W-1:0]          result;
    logic                                irq_stat;
    logic                                irq_mask;
    logic                                irq;
    sadc_pkg::sadc_fsm_t                 fsm;
    logic [sadc_pkg::CNT_W-1:0]          cnt;
    logic [sadc_pkg::CNT_W-1:0]          div_cnt;
    logic [7:0]                          hrc_acc;
    logic [sadc_pkg::N_MUX-1:0]          mux_sel;
    logic                                sample_hold;
    logic                                sar_load;
    logic                                sar_step;
  } sadc_state_t;

  sadc_state_t s_q;
  sadc_state_t s_d;

  logic [sadc_pkg::RES_W-1:0] sar_trial;

  sadc_sar u_sar (
    .clk       (clk),
    .reset     (reset),
    .load      (s_q.sar_load),
    .step      (s_q.sar_step),
    .comp_high (comp_high),
    .trial     (sar_trial)
  );

  logic [sadc_pkg::IDX_W-1:0] idx;
  logic [7:0]                 wbyte;
  logic                       access;
  logic                       wr;
  logic [8:0]                 acc_sum;
  logic                       hrc_tick;
  logic                       adc_tick;
  logic [sadc_pkg::CNT_W-1:0] div_len;
  logic [sadc_pkg::CNT_W-1:0] samp_len;
  logic                       go;
  logic [7:0]                 rd_byte;
  logic                       wr_ctl;
  logic                       wr_cfg2;
  logic                       wr_cfg0;
  logic                       wr_cfg1;
  logic                       wr_lo;
  logic                       wr_hi;
  logic                       wr_stat;
  logic                       wr_mask;
  logic                       samp_last;
  logic                       conv_last;
  logic                       sar_phase;

  assign idx    = wb_req.adr[sadc_pkg::ADR_LSB +: sadc_pkg::IDX_W];
  assign wbyte  = wb_req.dat[7:0];
  assign access = wb_req.cyc && wb_req.stb;
  // Write lands on the edge where the master sees ack
  assign wr     = access && s_q.ack && wb_req.we && wb_req.sel[0];

  // Read view of the register file
  always_comb begin
    rd_byte = 8'h00;
    case (idx)
      sadc_pkg::IDX_CTL: begin
        rd_byte[sadc_pkg::CTL_PWR_BIT]  = s_q.power;
        // Start reads back as busy
        rd_byte[sadc_pkg::CTL_GO_BIT]   = (s_q.fsm != sadc_pkg::SADC_IDLE);
        rd_byte[sadc_pkg::CTL_DONE_BIT] = s_q.done;
        rd_byte[sadc_pkg::CTL_CH_LSB +: sadc_pkg::CH_W] = s_q.chan;
      end
      sadc_pkg::IDX_CFG2: begin
        rd_byte[sadc_pkg::CFG2_LONG_BIT] = s_q.long_sample;
        rd_byte[sadc_pkg::CFG2_CK_LSB +: sadc_pkg::CK_W] = s_q.clk_sel;
      end
      sadc_pkg::IDX_CFG0: begin
        rd_byte = s_q.pin_sel[sadc_pkg::CFG0_W-1:0];
      end
      sadc_pkg::IDX_CFG1: begin
        rd_byte[sadc_pkg::CFG1_W-1:0] =
          s_q.pin_sel[sadc_pkg::N_PINS-1:sadc_pkg::CFG0_W];
      end
      sadc_pkg::IDX_RES_LO: begin
        rd_byte[sadc_pkg::RES_LO_LSB +: sadc_pkg::RES_LO_W] =
          s_q.result[sadc_pkg::RES_LO_W-1:0];
      end
      sadc_pkg::IDX_RES_HI: begin
        rd_byte = s_q.result[sadc_pkg::RES_W-1:sadc_pkg::RES_LO_W];
      end
      sadc_pkg::IDX_IRQ_STAT: begin
        rd_byte[sadc_pkg::IRQ_DONE_BIT] = s_q.irq_stat;
      end
      sadc_pkg::IDX_IRQ_MASK: begin
        rd_byte[sadc_pkg::IRQ_DONE_BIT] = s_q.irq_mask;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // One strobe per register, taken on the acknowledged write edge
  always_comb begin
    wr_ctl  = 1'b0;
    wr_cfg2 = 1'b0;
    wr_cfg0 = 1'b0;
    wr_cfg1 = 1'b0;
    wr_lo   = 1'b0;
    wr_hi   = 1'b0;
    wr_stat = 1'b0;
    wr_mask = 1'b0;
    if (wr) begin
      case (idx)
        sadc_pkg::IDX_CTL:      wr_ctl  = 1'b1;
        sadc_pkg::IDX_CFG2:     wr_cfg2 = 1'b1;
        sadc_pkg::IDX_CFG0:     wr_cfg0 = 1'b1;
        sadc_pkg::IDX_CFG1:     wr_cfg1 = 1'b1;
        sadc_pkg::IDX_RES_LO:   wr_lo   = 1'b1;
        sadc_pkg::IDX_RES_HI:   wr_hi   = 1'b1;
        sadc_pkg::IDX_IRQ_STAT: wr_stat = 1'b1;
        sadc_pkg::IDX_IRQ_MASK: wr_mask = 1'b1;
        // Unmapped writes are acked and dropped
        default:                wr_ctl  = 1'b0;
      endcase
    end
  end

  // Phase lengths depend only on settled configuration
  always_comb begin
    div_len   = sadc_pkg::sadc_div(s_q.clk_sel);
    samp_len  = s_q.long_sample ? sadc_pkg::SAMPLE_LONG
                                : sadc_pkg::SAMPLE_SHORT;
    samp_last = (s_q.cnt == samp_len - 6'h01);
    conv_last = (s_q.cnt == sadc_pkg::CONV_CLKS - 6'h01);
    // Twelve decisions; the last two clocks only let the result settle
    sar_phase = (s_q.cnt < sadc_pkg::RES_STEPS);
  end

  always_comb begin
    s_d          = s_q;
    s_d.ack      = 1'b0;
    s_d.sar_load = 1'b0;
    s_d.sar_step = 1'b0;
    go           = 1'b0;
    hrc_tick     = 1'b0;
    adc_tick     = 1'b0;

    // Fractional accumulator gives the oscillator rate on the system clock
    acc_sum = {1'b0, s_q.hrc_acc} + sadc_pkg::HRC_RATE;
    if (acc_sum >= sadc_pkg::SYS_RATE) begin
      s_d.hrc_acc = 8'(acc_sum - sadc_pkg::SYS_RATE);
      hrc_tick    = 1'b1;
    end else begin
      s_d.hrc_acc = acc_sum[7:0];
    end

    // Converter clock, restarted with each conversion
    if (s_q.fsm == sadc_pkg::SADC_IDLE) begin
      s_d.div_cnt = '0;
    end else if (hrc_tick) begin
      if (s_q.div_cnt == div_len - 6'h01) begin
        s_d.div_cnt = '0;
        adc_tick    = 1'b1;
      end else begin
        s_d.div_cnt = s_q.div_cnt + 6'h01;
      end
    end

    // Wishbone: one wait state, ack for one cycle
    if (access && !s_q.ack) begin
      s_d.ack   = 1'b1;
      s_d.rdata = {24'h000000, rd_byte};
    end

    // Busy writes are left to software discipline
    if (wr_ctl) begin
      s_d.power = wbyte[sadc_pkg::CTL_PWR_BIT];
      s_d.chan  = wbyte[sadc_pkg::CTL_CH_LSB +: sadc_pkg::CH_W];
      if (!wbyte[sadc_pkg::CTL_DONE_BIT]) begin
        s_d.done = 1'b0;
      end
      // Start needs power; zero in the start bit is ignored
      go = wbyte[sadc_pkg::CTL_GO_BIT] &&
           wbyte[sadc_pkg::CTL_PWR_BIT];
    end

    if (wr_cfg2) begin
      s_d.long_sample = wbyte[sadc_pkg::CFG2_LONG_BIT];
      s_d.clk_sel     = wbyte[sadc_pkg::CFG2_CK_LSB +: sadc_pkg::CK_W];
    end

    if (wr_cfg0) begin
      s_d.pin_sel[sadc_pkg::CFG0_W-1:0] = wbyte;
    end

    if (wr_cfg1) begin
      s_d.pin_sel[sadc_pkg::N_PINS-1:sadc_pkg::CFG0_W] =
        wbyte[sadc_pkg::CFG1_W-1:0];
    end

    if (wr_lo) begin
      s_d.result[sadc_pkg::RES_LO_W-1:0] =
        wbyte[sadc_pkg::RES_LO_LSB +: sadc_pkg::RES_LO_W];
    end

    if (wr_hi) begin
      s_d.result[sadc_pkg::RES_W-1:sadc_pkg::RES_LO_W] = wbyte;
    end

    // Clear comes first so a same-cycle completion still sets the flag
    if (wr_stat && wbyte[sadc_pkg::IRQ_DONE_BIT]) begin
      s_d.irq_stat = 1'b0;
    end

    if (wr_mask) begin
      s_d.irq_mask = wbyte[sadc_pkg::IRQ_DONE_BIT];
    end

    // Conversion sequence
    case (s_q.fsm)
      sadc_pkg::SADC_IDLE: begin
        s_d.sample_hold = 1'b0;
      end
      sadc_pkg::SADC_SAMPLE: begin
        if (adc_tick) begin
          if (samp_last) begin
            s_d.fsm         = sadc_pkg::SADC_CONVERT;
            s_d.cnt         = '0;
            s_d.sample_hold = 1'b0;
            s_d.sar_load    = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt + 6'h01;
          end
        end
      end
      sadc_pkg::SADC_CONVERT: begin
        if (adc_tick) begin
          // One decision per converter clock, twelve in all
          if (sar_phase) begin
            s_d.sar_step = 1'b1;
          end
          if (conv_last) begin
            s_d.result   = sar_trial;
            s_d.done     = 1'b1;
            s_d.irq_stat = 1'b1;
            s_d.fsm      = sadc_pkg::SADC_IDLE;
            s_d.cnt      = '0;
          end else begin
            s_d.cnt = s_q.cnt + 6'h01;
          end
        end
      end
      default: begin
        s_d.fsm = sadc_pkg::SADC_IDLE;
      end
    endcase

    // A fresh start restarts the sequence from sampling
    if (go) begin
      s_d.fsm         = sadc_pkg::SADC_SAMPLE;
      s_d.cnt         = '0;
      s_d.div_cnt     = '0;
      s_d.sample_hold = 1'b1;
      s_d.done        = 1'b0;
    end

    // Power loss aborts any conversion in flight
    if (!s_d.power) begin
      s_d.fsm         = sadc_pkg::SADC_IDLE;
      s_d.sample_hold = 1'b0;
      s_d.cnt         = '0;
    end

    // Input routing, nothing selected for reserved codes
    s_d.mux_sel = '0;
    if (s_d.power) begin
      if (s_d.chan <= sadc_pkg::CH_PIN_LAST) begin
        s_d.mux_sel[s_d.chan[3:0]] = 1'b1;
      end else if (s_d.chan == sadc_pkg::CH_QUARTER) begin
        s_d.mux_sel[sadc_pkg::MUX_QUARTER] = 1'b1;
      end
    end

    s_d.irq = s_d.irq_stat && s_d.irq_mask;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_rsp.ack                = s_q.ack;
  assign wb_rsp.dat                = s_q.rdata;
  assign analog.power_on           = s_q.power;
  assign analog.sample_hold        = s_q.sample_hold;
  assign analog.mux_sel            = s_q.mux_sel;
  assign analog.pin_analog_select  = s_q.pin_sel;
  assign analog.dac_code           = sar_trial;
  assign irq                       = s_q.irq;

endmodule : sadc_ctrl

`default_nettype wire

// ---- include/sadc_pkg.sv ----
package sadc_pkg;

  // Clock rates in MHz
  localparam int SYS_CLK_MHZ = 200;
  localparam int HRC_MHZ     = 24;
  localparam logic [8:0] SYS_RATE = 9'(SYS_CLK_MHZ);
  localparam logic [8:0] HRC_RATE = 9'(HRC_MHZ);

  // Bus geometry
  localparam int ADR_W  = 10;
  localparam int DAT_W  = 32;
  localparam int IDX_W  = 8;
  localparam int ADR_LSB = 2;

  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CFG2     = 8'hAA;
  localparam logic [IDX_W-1:0] IDX_CFG0     = 8'hAB;
  localparam logic [IDX_W-1:0] IDX_CFG1     = 8'hAC;
  localparam logic [IDX_W-1:0] IDX_CTL      = 8'hAD;
  localparam logic [IDX_W-1:0] IDX_RES_LO   = 8'hAE;
  localparam logic [IDX_W-1:0] IDX_RES_HI   = 8'hAF;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 8'hB0;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'hB1;

  // Control register fields
  localparam int CTL_PWR_BIT  = 7;
  localparam int CTL_GO_BIT   = 6;
  localparam int CTL_DONE_BIT = 5;
  localparam int CTL_CH_LSB   = 0;
  localparam int CH_W         = 5;

  // Configuration fields
  localparam int CFG2_LONG_BIT = 3;
  localparam int CFG2_CK_LSB   = 0;
  localparam int CK_W          = 3;
  localparam int N_PINS        = 10;
  localparam int CFG0_W        = 8;
  localparam int CFG1_W        = 2;
  localparam int N_MUX         = 11;
  localparam int MUX_QUARTER   = 10;
  localparam int RES_LO_LSB    = 4;
  localparam int RES_LO_W      = 4;
  localparam int IRQ_DONE_BIT  = 0;

  // Channel codes
  localparam logic [CH_W-1:0] CH_PIN_LAST = 5'h09;
  localparam logic [CH_W-1:0] CH_QUARTER  = 5'h1F;

  // Conversion timing in converter clocks
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] SAMPLE_SHORT = 6'h06;
  localparam logic [CNT_W-1:0] SAMPLE_LONG  = 6'h24;
  localparam logic [CNT_W-1:0] CONV_CLKS    = 6'h0E;
  localparam int RES_W = 12;
  localparam logic [CNT_W-1:0] RES_STEPS    = 6'h0C;
  localparam logic [RES_W-1:0] SAR_MSB      = 12'h800;

  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_SAMPLE,
    SADC_CONVERT
  } sadc_fsm_t;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [3:0]       sel;
    logic [DAT_W-1:0] dat;
  } sadc_wb_req_t;

  typedef struct packed {
    logic             ack;
    logic [DAT_W-1:0] dat;
  } sadc_wb_rsp_t;

  typedef struct packed {
    logic              power_on;
    logic              sample_hold;
    logic [N_MUX-1:0]  mux_sel;
    logic [N_PINS-1:0] pin_analog_select;
    logic [RES_W-1:0]  dac_code;
  } sadc_analog_t;

  // Converter clock divisor from the clock select code
  function automatic logic [CNT_W-1:0] sadc_div(input logic [CK_W-1:0] ck);
    case (ck)
      3'h0:    sadc_div = 6'h20;
      3'h1:    sadc_div = 6'h18;
      3'h2:    sadc_div = 6'h10;
      3'h3:    sadc_div = 6'h0C;
      3'h4:    sadc_div = 6'h08;
      3'h5:    sadc_div = 6'h06;
      3'h6:    sadc_div = 6'h04;
      default: sadc_div = 6'h03;
    endcase
  endfunction : sadc_div

endpackage : sadc_pkg

// ---- core/sadc_sar.sv ----
`timescale 1ns/10ps
`default_nettype none

module sadc_sar (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic                        load,
  input  wire logic                        step,
  input  wire logic                        comp_high,
  output logic [sadc_pkg::RES_W-1:0]       trial
);

  typedef struct packed {
    logic [sadc_pkg::RES_W-1:0] trial;
    logic [sadc_pkg::RES_W-1:0] probe;
  } sadc_sar_state_t;

  sadc_sar_state_t s_q;
  sadc_sar_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.trial = sadc_pkg::SAR_MSB;
      s_d.probe = sadc_pkg::SAR_MSB;
    end else if (step && (s_q.probe != '0)) begin
      // Keep the bit under test only if the input lies above the trial
      if (!comp_high) begin
        s_d.trial = s_q.trial & ~s_q.probe;
      end
      s_d.trial = s_d.trial | (s_q.probe >> 1);
      s_d.probe = s_q.probe >> 1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign trial = s_q.trial;

endmodule : sadc_sar

`default_nettype wire

// ---- verif/sadc_ctrl_props.sv ----
`timescale 1ns/10ps
`default_nettype none

module sadc_ctrl_props (
  input wire logic                   clk,
  input wire logic                   reset,
  input wire sadc_pkg::sadc_wb_req_t wb_req,
  input wire sadc_pkg::sadc_wb_rsp_t wb_rsp,
  input wire logic                   comp_high,
  input wire sadc_pkg::sadc_analog_t analog,
  input wire logic                   irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  logic       req;
  logic       wr;
  logic [7:0] ix;
  assign req = wb_req.cyc & wb_req.stb;
  assign wr  = req & wb_req.we & wb_rsp.ack & wb_req.sel[0];
  assign ix  = wb_req.adr[9:2];

  property p_ack; req && !wb_rsp.ack |=> wb_rsp.ack; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_pulse; wb_rsp.ack |=> !wb_rsp.ack; endproperty
  a_pulse: assert property (p_pulse) else $error("ack too long");
  property p_rdz;
    wb_rsp.ack && !wb_req.we |-> wb_rsp.dat[31:8] == 24'h000000;
  endproperty
  a_rdz: assert property (p_rdz) else $error("read upper bits");
  property p_pwr;
    wr && ix == sadc_pkg::IDX_CTL |=>
      analog.power_on == $past(wb_req.dat[7]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power bit");
  property p_go;
    wr && ix == sadc_pkg::IDX_CTL && wb_req.dat[7:6] == 2'b11 |=>
      analog.sample_hold;
  endproperty
  a_go: assert property (p_go) else $error("no start");
  property p_nogo;
    wr && ix == sadc_pkg::IDX_CTL && !wb_req.dat[6] &&
      !analog.sample_hold |=> !analog.sample_hold;
  endproperty
  a_nogo: assert property (p_nogo) else $error("false start");
  property p_smp;
    $rose(analog.sample_hold) |-> analog.sample_hold[*8];
  endproperty
  a_smp: assert property (p_smp) else $error("sampling short");
  property p_mux; $onehot0(analog.mux_sel); endproperty
  a_mux: assert property (p_mux) else $error("mux not one-hot");
  property p_off;
    !analog.power_on [*2] |->
      analog.mux_sel == 11'h000 && !analog.sample_hold;
  endproperty
  a_off: assert property (p_off) else $error("active unpowered");
  property p_pin;
    wr && ix == sadc_pkg::IDX_CFG0 |=>
      analog.pin_analog_select[7:0] == $past(wb_req.dat[7:0]);
  endproperty
  a_pin: assert property (p_pin) else $error("pin select");
endmodule : sadc_ctrl_props

bind sadc_ctrl sadc_ctrl_props u_props (.clk(clk), .reset(reset),
  .wb_req(wb_req), .wb_rsp(wb_rsp), .comp_high(comp_high),
  .analog(analog), .irq(irq));

`default_nettype wire

// ---- verif/sadc_afe_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module sadc_afe_model (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire sadc_pkg::sadc_analog_t analog,
  input  wire logic [10:0][11:0]      level,
  output logic                        comp_high
);
  logic [11:0] held_q;
  logic        ok_q;
  logic        tog_q;
  logic [11:0] pick;
  logic        ok;

  always_comb begin
    pick = 12'h000;
    ok   = 1'b0;
    for (int i = 0; i < 10; i++) begin
      if (analog.mux_sel[i] && analog.pin_analog_select[i]) begin
        pick = level[i];
        ok   = 1'b1;
      end
    end
    if (analog.mux_sel[10]) begin
      pick = level[10];
      ok   = 1'b1;
    end
  end

  // Tracks only while sampling, frozen for the approximation steps
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      held_q <= 12'h000;
      ok_q   <= 1'b0;
      tog_q  <= 1'b0;
    end else begin
      tog_q <= ~tog_q;
      if (analog.sample_hold) begin
        held_q <= pick;
        ok_q   <= ok & analog.power_on;
      end
    end
  end

  // Input sits mid-code, so an equal trial lies below it; an unrouted
  // or unpowered input answers with a changing, meaningless level
  assign comp_high = ok_q ? (held_q >= analog.dac_code) : tog_q;
endmodule : sadc_afe_model

`default_nettype wire

// ---- verif/sadc_ctrl_bench.sv ----
`timescale 1ns/10ps
`default_nettype none

module sadc_ctrl_bench;
  logic                   clk;
  logic                   reset;
  sadc_pkg::sadc_wb_req_t req;
  sadc_pkg::sadc_wb_rsp_t rsp;
  sadc_pkg::sadc_analog_t ana;
  logic                   comp;
  logic                   irq;
  logic [10:0][11:0]      level;
  logic [31:0]            r;
  logic                   m;
  int                     errors = 0;
  int                     samples_checked = 0;
  int                     cycles = 0;
  int                     seed;

  sadc_ctrl u_dut (.clk(clk), .reset(reset), .wb_req(req), .wb_rsp(rsp),
    .comp_high(comp), .analog(ana), .irq(irq));
  sadc_afe_model u_afe (.clk(clk), .reset(reset), .analog(ana),
    .level(level), .comp_high(comp));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic complete_run;
    $display("Checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] ix,
                    input logic [7:0] d);
    req.cyc <= 1'b1;
    req.stb <= 1'b1;
    req.we  <= w;
    req.adr <= {ix, 2'b00};
    req.dat <= {24'h000000, d};
    do begin
      @(posedge clk);
    end while (rsp.ack !== 1'b1);
    r = rsp.dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic rd(input string n, input logic [7:0] ix,
                    input logic [7:0] e);
    wb(1'b0, ix, 8'h00);
    chk(n, {24'h000000, e}, r);
  endtask : rd

  function automatic int exp_t(input logic lg);
    exp_t = (lg ? 50 : 20) * 3 * sadc_pkg::SYS_CLK_MHZ / sadc_pkg::HRC_MHZ;
  endfunction : exp_t

  task automatic conv(input logic [4:0] ch, input logic lg);
    int          t;
    logic [11:0] v;
    v = 12'($random(seed));
    level[(ch == 5'h1F) ? 4'hA : ch[3:0]] <= v;
    wb(1'b1, 8'hAA, {4'h0, lg, 3'h7});
    t = cycles;
    wb(1'b1, 8'hAD, {3'b110, ch});
    chk("mux", (ch == 5'h1F) ? 32'h400 : 32'h1 << ch, 32'(ana.mux_sel));
    do begin
      wb(1'b0, 8'hAD, 8'h00);
    end while (r[5] !== 1'b1);
    t = cycles - t - exp_t(lg);
    chk("time", 32'h1, 32'(t > -40 && t < 40));
    chk("irq", {31'h0, m}, {31'h0, irq});
    rd("ctl", 8'hAD, {3'b101, ch});
    rd("res_hi", 8'hAF, v[11:4]);
    rd("res_lo", 8'hAE, {v[3:0], 4'h0});
    rd("stat", 8'hB0, 8'h01);
    wb(1'b1, 8'hB0, 8'h01);
    @(posedge clk);
    chk("irq_clr", 32'h0, {31'h0, irq});
    rd("done_kept", 8'hAD, {3'b101, ch});
  endtask : conv

  initial begin
    seed = 32'hAF3E0975;
    reset = 1'b1;
    req = '0;
    req.sel = 4'hF;
    level = '0;
    m = 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 8'hAA; i <= 8'hB1; i++) begin
      rd("por", 8'(i), 8'h00);
    end
    wb(1'b1, 8'h10, 8'hFF);
    rd("unmapped", 8'h10, 8'h00);
    wb(1'b1, 8'hAD, 8'h40);
    rd("no_power", 8'hAD, 8'h00);
    wb(1'b1, 8'hAB, 8'hFF);
    wb(1'b1, 8'hAC, 8'h03);
    chk("pins", 32'h3FF, 32'(ana.pin_analog_select));
    wb(1'b1, 8'hB1, 8'h01);
    for (int c = 0; c < 10; c++) begin
      conv(5'(c), 1'b0);
    end
    conv(5'h1F, 1'b1);
    wb(1'b1, 8'hAD, 8'h85);
    rd("done_clr", 8'hAD, 8'h85);
    m = 1'b0;
    wb(1'b1, 8'hB1, 8'h00);
    conv(5'h03, 1'b0);
    complete_run();
  end
endmodule : sadc_ctrl_bench

`default_nettype wire
